/* File: common/pbs_burst_if.sv */
// Burst address carrier between the port and its address sequencer
`timescale 1ns/1ps
interface pbs_burst_if #(parameter int ADDR_W = 10);
    logic              load;
    logic              advance;
    logic              hold;
    logic              interleave;
    logic [ADDR_W-1:0] base_addr;
    logic [ADDR_W-1:0] cur_addr;
    modport ctrl (output load, output advance, output hold, output interleave, output base_addr, input cur_addr);
    modport seq  (input load, input advance, input hold, input interleave, input base_addr, output cur_addr);
endinterface

/* File: common/pbs_pkg.sv */
// Shared constants and types for the pipelined burst SRAM port
package pbs_pkg;
    localparam int ADDR_W_DEF     = 10;
    localparam int BYTES_DEF      = 4;
    localparam int BURST_BITS     = 2;
    localparam int SLEEP_CYC      = 2;
    localparam logic [1:0] BEAT_RESET = 2'h0;

    typedef enum logic [1:0] {
        PBS_OP_IDLE,
        PBS_OP_READ,
        PBS_OP_WRITE
    } pbs_op_e;

    typedef enum logic [1:0] {
        PBS_AWAKE,
        PBS_ENTERING,
        PBS_ASLEEP,
        PBS_LEAVING
    } pbs_sleep_e;
endpackage

/* File: dv/pbs_host_model.sv */
// Host controller model driving the port's command and write-data pins
`timescale 1ns/1ps
module pbs_host_model (
    input  wire logic   core_clk_in,
    output logic        clock_qualifier_n_out,
    output logic        chip_select_1_n_out,
    output logic        chip_select_2_out,
    output logic        chip_select_3_n_out,
    output logic        advance_load_n_out,
    output logic        write_select_n_out,
    output logic [3:0]  byte_lane_write_n_out,
    output logic        output_enable_n_out,
    output logic        burst_mode_out,
    output logic        sleep_request_out,
    output logic [9:0]  addr_out,
    output logic [35:0] wdata_out
);
    logic [35:0] wd;
    logic [36:0] p0, p1;
    logic        wr_burst, oe_s, md_s, sl_s;
    initial begin
        {clock_qualifier_n_out, chip_select_1_n_out, chip_select_2_out, chip_select_3_n_out} = 4'h5;
        {advance_load_n_out, write_select_n_out, byte_lane_write_n_out} = 6'h1F;
        {output_enable_n_out, burst_mode_out, sleep_request_out, oe_s, md_s, sl_s, wr_burst} = 7'h00;
        {addr_out, wdata_out, wd, p0, p1} = '0;
    end
    task automatic pins(input logic oe, input logic md, input logic sl);
        {oe_s, md_s, sl_s} = {oe, md, sl};
    endtask
    // ====================================
    // One beat, driven just after a rising edge
    task automatic beat(input logic sel, input logic adv_n, input logic we_n, input logic [3:0] bw_n,
                        input logic [9:0] a, input logic [35:0] d, input logic q_n);
        #1;
        {output_enable_n_out, burst_mode_out, sleep_request_out} = {oe_s, md_s, sl_s};
        clock_qualifier_n_out = q_n;
        {chip_select_1_n_out, chip_select_2_out, chip_select_3_n_out} = sel ? 3'h2 : 3'h5;
        {advance_load_n_out, write_select_n_out, byte_lane_write_n_out} = {adv_n, we_n, bw_n};
        addr_out = a;
        wd = d;
        @(posedge core_clk_in);
    endtask
    // Write data two qualified edges after its beat; a released bus toggles
    always @(posedge core_clk_in) begin
        if (!clock_qualifier_n_out) begin
            if (!advance_load_n_out)
                wr_burst = !chip_select_1_n_out && chip_select_2_out && !chip_select_3_n_out && !write_select_n_out;
            p1 = p0;
            p0 = {wr_burst, wd};
        end
        #1;
        wdata_out = p1[36] ? p1[35:0] : ~wdata_out;
    end
endmodule

/* File: dv/pbs_sram_port_props.sv */
// Pin-level checks for the burst SRAM port
`timescale 1ns/1ps
module pbs_sram_port_props #(
    parameter int BYTES = 4
) (
    input wire logic               core_clk_in,
    input wire logic               reset_in,
    input wire logic               clock_qualifier_n_in,
    input wire logic               chip_select_1_n_in,
    input wire logic               chip_select_2_in,
    input wire logic               chip_select_3_n_in,
    input wire logic               advance_load_n_in,
    input wire logic               write_select_n_in,
    input wire logic               output_enable_n_in,
    input wire logic               sleep_request_in,
    input wire logic [BYTES*8-1:0] data_out,
    input wire logic               data_oe_n_out,
    input wire logic               asleep_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    wire q  = !clock_qualifier_n_in;
    wire ld = q && !advance_load_n_in;
    wire sl = !chip_select_1_n_in && chip_select_2_in && !chip_select_3_n_in;
    wire oe = q && !output_enable_n_in;
    sequence s_wr;
        ld && sl && !write_select_n_in;
    endsequence
    sequence s_rd;
        ld && sl && write_select_n_in;
    endsequence
    sequence s_off;
        ld && !sl;
    endsequence
    // ====================================
    // Output timing
    a_stall_freeze: assert property (clock_qualifier_n_in |=> $stable(data_out) && $stable(data_oe_n_out))
        else $error("outputs moved on an ignored edge");
    a_read_drives: assert property (oe [*4] ##0 s_rd ##1 oe ##1 oe |=> !data_oe_n_out)
        else $error("read data not driven");
    a_write_hiz: assert property (s_wr ##1 q ##1 q |=> data_oe_n_out)
        else $error("driving during write data");
    a_deselect_hiz: assert property (s_off ##1 q ##1 q |=> data_oe_n_out)
        else $error("driving after deselect");
    a_oe_masks: assert property ((q && output_enable_n_in) [*4] |=> data_oe_n_out)
        else $error("driving with output enable high");
    a_reset_idle: assert property ($fell(reset_in) |-> data_oe_n_out && data_out == '0 && !asleep_out)
        else $error("not idle after reset");
    a_sleep_enter: assert property ((q && sleep_request_in) [*8] |=> asleep_out)
        else $error("sleep not entered");
    a_sleep_leave: assert property ((q && !sleep_request_in) [*8] |=> !asleep_out)
        else $error("sleep not left");
    a_sleep_quiet: assert property (asleep_out |-> data_oe_n_out)
        else $error("driving while asleep");
endmodule

bind pbs_sram_port pbs_sram_port_props #(.BYTES(BYTES)) u_props (.core_clk_in, .reset_in, .clock_qualifier_n_in,
    .chip_select_1_n_in, .chip_select_2_in, .chip_select_3_n_in, .advance_load_n_in, .write_select_n_in,
    .output_enable_n_in, .sleep_request_in, .data_out, .data_oe_n_out, .asleep_out);

/* File: dv/pbs_sram_port_tb_top.sv */
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
module pbs_sram_port_tb_top;
    logic        core_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        clock_qualifier_n_in, chip_select_1_n_in, chip_select_2_in, chip_select_3_n_in;
    logic        advance_load_n_in, write_select_n_in, output_enable_n_in, burst_mode_in, sleep_request_in;
    logic        data_oe_n_out, asleep_out, bon, btype, wv0, wv1, rdue, chk;
    logic [3:0]  byte_lane_write_n_in, parity_lines_in, parity_lines_out, wb0, wb1;
    logic [9:0]  addr_in, base, cur, wa0, wa1;
    logic [9:0]  wa [8];
    logic [31:0] data_in, data_out;
    logic [35:0] wdata, rexp, rold;
    logic [35:0] mem [int];
    logic [1:0]  beat, st;
    logic        slp;
    int          n_mismatch = 0;
    int          num_checks = 0;
    always #4 core_clk_in = ~core_clk_in;
    assign {parity_lines_in, data_in} = wdata;
    pbs_sram_port i_dut (.*);
    pbs_host_model i_host (.core_clk_in, .clock_qualifier_n_out(clock_qualifier_n_in),
        .chip_select_1_n_out(chip_select_1_n_in), .chip_select_2_out(chip_select_2_in),
        .chip_select_3_n_out(chip_select_3_n_in), .advance_load_n_out(advance_load_n_in),
        .write_select_n_out(write_select_n_in), .byte_lane_write_n_out(byte_lane_write_n_in),
        .output_enable_n_out(output_enable_n_in), .burst_mode_out(burst_mode_in),
        .sleep_request_out(sleep_request_in), .addr_out(addr_in), .wdata_out(wdata));
    task automatic chk36(input string nm, input logic [35:0] e, input logic [35:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic idle(input int n);
        i_host.beat(0, 0, 1, 4'hF, 0, 0, 0);
        repeat (n - 1) i_host.beat(0, 1, 0, 4'h0, 0, 0, 0);
    endtask
    // Settled copy of the sleep flag, safe to read at a rising edge
    always @(negedge core_clk_in) slp = asleep_out;
    task automatic wait_sleep(input logic lv);
        for (int n = 0; n < 30 && slp !== lv; n++) i_host.beat(0, 0, 1, 4'hF, 0, 0, 0);
        chk36("asleep", {35'h0, lv}, {35'h0, slp});
        if (slp !== lv) complete_run();
    endtask
    // ====================================
    // Reference model of the array and burst sequencing
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            {bon, wv0, wv1, rdue} = 4'h0;
        end else if (!clock_qualifier_n_in) begin
            for (int i = 0; i < 4; i++) begin
                if (wv1 && !wb1[i]) mem[wa1][8*i+:8] = data_in[8*i+:8];
                if (wv1 && !wb1[i]) mem[wa1][32+i] = parity_lines_in[i];
            end
            wv1 = wv0;
            wa1 = wa0;
            wb1 = wb0;
            wv0 = 1'b0;
            chk = rdue;
            rold = rexp;
            rdue = 1'b0;
            if (!advance_load_n_in) begin
                bon = !chip_select_1_n_in && chip_select_2_in && !chip_select_3_n_in;
                btype = !write_select_n_in;
                base = addr_in;
                beat = 2'h0;
            end else
                beat = beat + 2'h1;
            cur = {base[9:2], burst_mode_in ? base[1:0] ^ beat : base[1:0] + beat};
            if (bon && btype) {wv0, wa0, wb0} = {1'b1, cur, byte_lane_write_n_in};
            if (bon && !btype) {rdue, rexp} = {1'b1, mem[int'(cur)]};
            if (chk) begin
                #2;
                chk36("read word", rold, {parity_lines_out, data_out});
            end
        end
    end
    initial begin
        void'($urandom(79));
        repeat (5) @(posedge core_clk_in);
        #1;
        reset_in = 1'b0;
        @(posedge core_clk_in);
        // Burst writes, then burst reads in the other order with a stall
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 4; s++) begin
                i_host.pins(0, m[0], 0);
                for (int b = 0; b < 4; b++) i_host.beat(b == 0 || 1'($urandom), b != 0, b != 0 && 1'($urandom),
                    4'h0, 10'(m * 16 + s * 5), {4'($urandom), $urandom}, 0);
                idle(2);
                i_host.pins(0, ~m[0], 0);
                st = 2'($urandom);
                for (int b = 0; b < 4; b++) begin
                    if (b == 2) i_host.beat(0, 0, 0, 4'h0, 0, 0, 1);
                    i_host.beat(b == 0 || 1'($urandom), b != 0, b == 0 || 1'($urandom), 4'hF,
                        10'(m * 16 + s * 4 + st), 36'h0, 0);
                end
            end
        end
        // Single writes with random lane strobes, read back with output enable high
        for (int k = 0; k < 8; k++) begin
            wa[k] = 10'($urandom % 32);
            i_host.beat(1, 0, 0, k == 0 ? 4'hF : 4'($urandom), wa[k], {4'($urandom), $urandom}, 0);
        end
        idle(2);
        i_host.pins(1, 0, 0);
        for (int k = 0; k < 8; k++) i_host.beat(1, 0, 1, 4'hF, wa[k], 36'h0, 0);
        idle(3);
        i_host.pins(0, 0, 1);
        wait_sleep(1'b1);
        idle(9);
        i_host.pins(0, 0, 0);
        wait_sleep(1'b0);
        idle(4);
        for (int k = 0; k < 8; k++) i_host.beat(1, 0, 1, 4'hF, wa[k], 36'h0, 0);
        idle(3);
        complete_run();
    end
endmodule

/* File: rtl/pbs_burst_seq.sv */
// Burst address sequencer: loaded start address plus two-bit beat count
`timescale 1ns/1ps
module pbs_burst_seq #(
    parameter int ADDR_W = 10
) (
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    pbs_burst_if.seq  bus
);
    logic [ADDR_W-1:0] start;
    logic [1:0]        beat;

    function automatic logic [1:0] burst_low(input logic [1:0] s, input logic [1:0] b, input logic il);
        burst_low = il ? (s ^ b) : 2'(s + b); // RL25 RL8
    endfunction

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            start <= '0;
            beat  <= pbs_pkg::BEAT_RESET;
        end else if (!bus.hold) begin
            if (bus.load) begin
                start <= bus.base_addr;
                beat  <= pbs_pkg::BEAT_RESET;
            end else if (bus.advance) begin
                beat <= 2'(beat + 2'h1); // RL7
            end
        end
    end

    // Address of the beat that an advance at the coming edge issues
    assign bus.cur_addr = {start[ADDR_W-1:2], burst_low(start[1:0], 2'(beat + 2'h1), bus.interleave)};
endmodule

/* File: rtl/pbs_sram_port.sv */
// Pipelined common-I/O burst SRAM port: command decode, pipeline and storage
// Behaviour
// (RL1) Clock qualifier high freezes all state; the code still updates the synchronisers and sleep state
// (RL2) Selected, write high, load low starts read
// (RL3) Read data appears one qualified edge later
// (RL4) Data driven only while output enable low
// (RL5) New command accepted every cycle
// (RL6) Deselect tristates outputs after next edge
// (RL7) Burst counter gives four beats per address
// (RL8) Mode selects linear or interleaved wrapping order
// (RL9) Advance high steps counter regardless of selects
// (RL10) Burst keeps read/write type latched at load
// (RL11) Selected with write low starts write
// (RL12) Outputs tristate edge after write command
// (RL13) Write data captured second edge after command
// (RL14) Only strobed byte lanes are written
// (RL15) Host avoids driving while outputs active
// (RL16) Write continuation ignores selects and write select
// (RL17) Host drives byte strobes every burst beat
// (RL18) Sleep keeps data, two cycles in/out
// (RL19) Operations pending at sleep are dropped
// (RL20) Host deselects before and after sleep
// (RL21) Sleep input defaults low when unconnected
// (RL22) Host reloads address after deselect
// (RL23) Power-up deselected with outputs tristated
// (RL24) Write with no strobes keeps lines tristated
// (RL25) Interleave uses XOR, linear adds modulo four
`timescale 1ns/1ps
module pbs_sram_port #(
    parameter int ADDR_W = pbs_pkg::ADDR_W_DEF,
    parameter int BYTES  = pbs_pkg::BYTES_DEF
) (
    input  wire logic               core_clk_in,
    input  wire logic               reset_in,
    input  wire logic               clock_qualifier_n_in,
    input  wire logic               chip_select_1_n_in,
    input  wire logic               chip_select_2_in,
    input  wire logic               chip_select_3_n_in,
    input  wire logic               advance_load_n_in,
    input  wire logic               write_select_n_in,
    input  wire logic [BYTES-1:0]   byte_lane_write_n_in,
    input  wire logic               output_enable_n_in,
    input  wire logic               burst_mode_in,
    input  wire logic               sleep_request_in,
    input  wire logic [ADDR_W-1:0]  addr_in,
    input  wire logic [BYTES*8-1:0] data_in,
    input  wire logic [BYTES-1:0]   parity_lines_in,
    output logic      [BYTES*8-1:0] data_out,
    output logic      [BYTES-1:0]   parity_lines_out,
    output logic                    data_oe_n_out,
    output logic                    asleep_out
);
    localparam int LANE_W = 9;

    logic [BYTES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Two-flop synchronisers for the asynchronous pins
    logic               oe_meta;
    logic               oe_sync;
    logic               sleep_meta;
    logic               sleep_sync;

    pbs_pkg::pbs_op_e    burst_op;
    pbs_pkg::pbs_op_e    stage1_op;
    logic [ADDR_W-1:0]   stage1_addr;
    logic [BYTES-1:0]    stage1_lane_n;
    pbs_pkg::pbs_op_e    stage2_op;
    logic [ADDR_W-1:0]   stage2_addr;
    logic [BYTES-1:0]    stage2_lane_n;
    logic                read_drive;

    pbs_pkg::pbs_sleep_e sleep_state;
    logic [1:0]          sleep_cnt;
    logic                sleeping;

    logic                qual;
    logic                selected;
    logic                cmd_load;
    logic                cmd_adv;
    pbs_pkg::pbs_op_e    next_op;

    pbs_burst_if #(.ADDR_W(ADDR_W)) burst ();

    pbs_burst_seq #(.ADDR_W(ADDR_W)) u_seq (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .bus         (burst)
    );

    // ==========================================================
    // Input synchronisers
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            oe_meta <= 1'b1;
            oe_sync <= 1'b1;
        end else begin
            oe_meta <= output_enable_n_in;
            oe_sync <= oe_meta;
        end
    end

    // Sleep pin idles low, so a floating pin keeps the port awake
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end else begin
            sleep_meta <= sleep_request_in; // RL21
            sleep_sync <= sleep_meta;
        end
    end

    // ==========================================================
    // Command decode
    assign sleeping = (sleep_state != pbs_pkg::PBS_AWAKE);
    assign qual     = !clock_qualifier_n_in && !sleeping; // RL1
    assign selected = !chip_select_1_n_in && chip_select_2_in && !chip_select_3_n_in;
    assign cmd_load = !advance_load_n_in;
    assign cmd_adv  = advance_load_n_in; // RL9 RL16

    always_comb begin
        next_op = pbs_pkg::PBS_OP_IDLE;
        if (cmd_load) begin
            if (selected) begin
                next_op = write_select_n_in ? pbs_pkg::PBS_OP_READ : pbs_pkg::PBS_OP_WRITE; // RL2 RL11
            end
        end else begin
            next_op = burst_op; // RL10
        end
    end

    assign burst.load       = qual && cmd_load && selected;
    assign burst.advance    = qual && cmd_adv;
    assign burst.hold       = !qual;
    assign burst.interleave = burst_mode_in; // RL8
    assign burst.base_addr  = addr_in;

    // ==========================================================
    // Burst type latch
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            burst_op <= pbs_pkg::PBS_OP_IDLE; // RL23
        end else if (sleeping) begin
            burst_op <= pbs_pkg::PBS_OP_IDLE; // RL19
        end else if (qual && cmd_load) begin
            burst_op <= next_op; // RL10
        end
    end

    // ==========================================================
    // Command pipeline, one new command per qualified edge
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stage1_op <= pbs_pkg::PBS_OP_IDLE;
        end else if (sleeping) begin
            stage1_op <= pbs_pkg::PBS_OP_IDLE; // RL19
        end else if (qual) begin
            stage1_op <= next_op; // RL5
        end
    end

    // Loaded address, or the next burst address on a continuation
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stage1_addr <= '0;
        end else if (qual) begin
            stage1_addr <= cmd_load ? addr_in : burst.cur_addr; // RL7 RL16
        end
    end

    // Strobes are taken afresh on every beat
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stage1_lane_n <= '1;
        end else if (qual) begin
            stage1_lane_n <= byte_lane_write_n_in; // RL17
        end
    end

    // ==========================================================
    // Second stage: the data phase of a write
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stage2_op <= pbs_pkg::PBS_OP_IDLE;
        end else if (sleeping) begin
            stage2_op <= pbs_pkg::PBS_OP_IDLE; // RL19
        end else if (qual) begin
            stage2_op <= stage1_op;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stage2_addr <= '0;
        end else if (qual) begin
            stage2_addr <= stage1_addr;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stage2_lane_n <= '1;
        end else if (qual) begin
            stage2_lane_n <= stage1_lane_n;
        end
    end

    // Address used by the current beat: loaded address or next burst address
    logic [ADDR_W-1:0] beat_addr;
    always_comb begin
        beat_addr = stage1_addr;
    end

    // ==========================================================
    // Write completion at the second qualified edge
    always_ff @(posedge core_clk_in) begin
        if (!reset_in && qual && stage2_op == pbs_pkg::PBS_OP_WRITE) begin
            for (int i = 0; i < BYTES; i++) begin
                if (!stage2_lane_n[i]) begin
                    mem[stage2_addr][i*LANE_W +: LANE_W] <= {parity_lines_in[i], data_in[i*8 +: 8]}; // RL13 RL14
                end
            end
        end
    end

    // ==========================================================
    // Read output register, one qualified edge after the command
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            read_drive <= 1'b0;
        end else if (sleeping) begin
            read_drive <= 1'b0;
        end else if (qual) begin
            read_drive <= (stage1_op == pbs_pkg::PBS_OP_READ); // RL3 RL6 RL12 RL24
        end
    end

    // Read data register keeps the last word between read beats
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            data_out         <= '0;
            parity_lines_out <= '0;
        end else if (qual) begin
            if (stage1_op == pbs_pkg::PBS_OP_READ) begin
                for (int i = 0; i < BYTES; i++) begin
                    data_out[i*8 +: 8]  <= mem[beat_addr][i*LANE_W +: 8]; // RL3
                    parity_lines_out[i] <= mem[beat_addr][i*LANE_W + 8];
                end
            end
        end
    end

    // Enable is low only while a read beat is shown and the synchronised enable pin is low
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            data_oe_n_out <= 1'b1; // RL23
        end else if (sleeping) begin
            data_oe_n_out <= 1'b1; // RL18
        end else if (qual) begin
            data_oe_n_out <= !(read_drive && !oe_sync); // RL1 RL4
        end
    end

    // ==========================================================
    // Sleep indicator: high from full entry until exit completes
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            asleep_out <= 1'b0;
        end else if (sleep_state == pbs_pkg::PBS_ENTERING && sleep_cnt == 2'(pbs_pkg::SLEEP_CYC)) begin
            asleep_out <= 1'b1; // RL18
        end else if (sleep_state == pbs_pkg::PBS_LEAVING && sleep_cnt == 2'(pbs_pkg::SLEEP_CYC)) begin
            asleep_out <= 1'b0; // RL18
        end
    end

    // ==========================================================
    // Sleep entry and exit, two cycles each
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sleep_state <= pbs_pkg::PBS_AWAKE;
            sleep_cnt   <= 2'h0;
        end else begin
            case (sleep_state)
                pbs_pkg::PBS_AWAKE: begin
                    if (sleep_sync) begin
                        sleep_state <= pbs_pkg::PBS_ENTERING; // RL18
                        sleep_cnt   <= 2'h1;
                    end
                end
                pbs_pkg::PBS_ENTERING: begin
                    if (sleep_cnt == 2'(pbs_pkg::SLEEP_CYC)) begin
                        sleep_state <= pbs_pkg::PBS_ASLEEP;
                    end else begin
                        sleep_cnt <= 2'(sleep_cnt + 2'h1);
                    end
                end
                pbs_pkg::PBS_ASLEEP: begin
                    if (!sleep_sync) begin
                        sleep_state <= pbs_pkg::PBS_LEAVING;
                        sleep_cnt   <= 2'h1;
                    end
                end
                pbs_pkg::PBS_LEAVING: begin
                    if (sleep_cnt == 2'(pbs_pkg::SLEEP_CYC)) begin
                        sleep_state <= pbs_pkg::PBS_AWAKE; // RL18
                    end else begin
                        sleep_cnt <= 2'(sleep_cnt + 2'h1);
                    end
                end
                default: begin
                    sleep_state <= pbs_pkg::PBS_AWAKE;
                end
            endcase
        end
    end
endmodule
